/* File: pkg/srwp_pkg.sv */
package srwp_pkg;

  // ----------------------------------------------------------------------
  // command opcodes seen by this block
  // ----------------------------------------------------------------------
  localparam logic [7:0] OP_WRSR1 = 8'h01;      // write status register 1
  localparam logic [7:0] OP_WRSR2 = 8'h31;      // write status register 2
  localparam logic [7:0] OP_WRSR3 = 8'h11;      // write status register 3
  localparam logic [7:0] OP_WRSR_ADDR = 8'h71;  // write addressed status register
  localparam logic [7:0] OP_BLK_LOCK = 8'h36;   // lock one block
  localparam logic [7:0] OP_BLK_UNLOCK = 8'h39; // unlock one block

  // ----------------------------------------------------------------------
  // command carrier widths and register selectors for the addressed write
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 24;                   // command address width
  localparam logic [7:0] SEL_SR1 = 8'h01;       // addressed write to register 1
  localparam logic [7:0] SEL_SR2 = 8'h02;       // addressed write to register 2
  localparam logic [7:0] SEL_SR3 = 8'h03;       // addressed write to register 3

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int SR1_PROT_LOW_BIT = 7;          // protect_select_low in register 1
  localparam int SR2_PROT_HIGH_BIT = 0;         // protect_select_high in register 2
  localparam int SR2_QE_BIT = 1;                // quad_lines_enable in register 2

  // ----------------------------------------------------------------------
  // drive strength codes and reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0] DRV_RESERVED = 2'h0;   // not a legal strength
  localparam logic [1:0] DRV_FULL = 2'h1;       // full strength, the default
  localparam logic [1:0] DRV_TWO_THIRDS = 2'h2; // 66 percent
  localparam logic [1:0] DRV_ONE_THIRD = 2'h3;  // 33 percent
  localparam logic PIN_FN_HOLD = 1'b0;          // shared pin acts as hold
  localparam logic PIN_FN_RESET = 1'b1;         // shared pin acts as reset
  localparam logic SCHEME_REGION = 1'b0;        // region protection scheme
  localparam logic SCHEME_BLOCK = 1'b1;         // per-block lock scheme
  localparam logic BLOCK_LOCK_RESET = 1'b1;     // every block locked after reset
  localparam logic QE_RESET = 1'b0;             // quad lines off after power-on

  // ----------------------------------------------------------------------
  // protect select pairs, written {high, low}
  // ----------------------------------------------------------------------
  localparam logic [1:0] PSEL_SOFTWARE = 2'h0;  // software protected
  localparam logic [1:0] PSEL_HARDWARE = 2'h1;  // pin controlled
  localparam logic [1:0] PSEL_LOCKDOWN = 2'h2;  // locked until reset
  localparam logic [1:0] PSEL_LOCKED = 2'h3;    // lockdown or one-time

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,                            // reload volatile bits
    ST_RUN = 2'b01                              // normal operation
  } srwp_state_t;

  typedef enum logic [2:0] {
    PT_SOFTWARE = 3'h0,
    PT_HW_PROT = 3'h1,
    PT_HW_UNPROT = 3'h2,
    PT_LOCKDOWN = 3'h3,
    PT_OTP = 3'h4
  } srwp_ptype_t;

  typedef struct packed {
    logic [7:0] opcode;                         // decoded command byte
    logic [ADDR_W-1:0] addr;                    // address bytes, if any
    logic [7:0] data;                           // first data byte, if any
  } srwp_cmd_t;

  typedef struct packed {
    logic pin_fn;                               // hold or reset select
    logic [1:0] drive;                          // output_strength_field
    logic [1:0] rsvd_hi;                        // reads zero
    logic scheme;                               // protection_scheme_select
    logic [1:0] rsvd_lo;                        // reads zero
  } srwp_sr3_t;

  localparam srwp_sr3_t SR3_RESET = '{PIN_FN_HOLD, DRV_FULL, 2'h0, SCHEME_REGION, 2'h0};

endpackage

/* File: design/srwp_guard.sv */
`timescale 1ns/100ps
`default_nettype none

// decides whether a status write may land, purely from present levels
module srwp_guard (
  input wire logic [1:0] i_psel,                // {protect_select_high, low}
  input wire logic i_lock,                      // permanent_lock_bit
  input wire logic i_wp,                        // write-protect pin level
  input wire logic i_qe,                        // quad_lines_enable
  input wire logic i_wel,                       // write_enable_latch
  output logic o_allowed,                       // write may proceed
  output srwp_pkg::srwp_ptype_t o_ptype         // current protection type
);

  // ----------------------------------------------------------------------
  // protection decode
  // ----------------------------------------------------------------------
  logic wp_eff;                                 // pin as the protect logic sees it

  // with quad lines on the pin carries data, so it never protects
  assign wp_eff = i_qe | i_wp;

  always_comb begin
    o_allowed = 1'b0;
    o_ptype = srwp_pkg::PT_SOFTWARE;
    case (i_psel)
      srwp_pkg::PSEL_SOFTWARE: begin
        // pin has no meaning here, only the latch matters
        o_ptype = srwp_pkg::PT_SOFTWARE;
        o_allowed = i_wel;
      end
      srwp_pkg::PSEL_HARDWARE: begin
        if (wp_eff) begin
          o_ptype = srwp_pkg::PT_HW_UNPROT;
          o_allowed = i_wel;
        end else begin
          o_ptype = srwp_pkg::PT_HW_PROT;
          o_allowed = 1'b0;
        end
      end
      srwp_pkg::PSEL_LOCKDOWN: begin
        o_ptype = srwp_pkg::PT_LOCKDOWN;
        o_allowed = 1'b0;
      end
      srwp_pkg::PSEL_LOCKED: begin
        // lock bit separates a reset-clearable lockdown from one-time
        o_ptype = i_lock ? srwp_pkg::PT_OTP : srwp_pkg::PT_LOCKDOWN;
        o_allowed = 1'b0;
      end
      default: begin
        o_ptype = srwp_pkg::PT_SOFTWARE;
        o_allowed = 1'b0;
      end
    endcase
  end

endmodule

`default_nettype wire

/* File: design/srwp_top.sv */
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - both selects zero: write needs latch only
// - select 0,1 and pin low: refuse writes
// - select 0,1 and pin high: latch permits write
// - select 1,0: refuse writes until reset
// - select 1,1, lock clear: refuse until reset
// - select 1,1, lock set: refuse forever
// - reset copies stored 0,0 or 0,1 unchanged
// - reset turns stored 1,0 into 0,0
// - reset turns stored 1,1 unlocked into 0,1
// - reset keeps 1,1 when lock set
// - bit 7 selects hold or reset pin
// - pin function only while quad lines off
// - bits 6:5 set drive, default full
// - bit 2 picks region or block scheme
// - all block locks set after every reset
// - 36h locks, 39h unlocks addressed block
// - quad lines disable pin protect functions
// - high select sits at register 2 bit 0
module srwp_top #(
  parameter int NUM_BLOCKS = 64,                // individually lockable blocks
  parameter int BLOCK_SHIFT = 16                // address bits inside one block
) (
  input wire logic I_MCLK,                      // serial clock
  input wire logic I_RESETN,                    // power-on or hardware reset
  input wire logic I_SW_RESET,                  // software reset pulse
  input wire logic [1:0] I_NV_PSEL,             // stored {high, low} selects
  input wire logic I_NV_LOCK,                   // stored permanent_lock_bit
  input wire logic I_WP_PIN,                    // write-protect pin level
  input wire logic I_WEL,                       // write_enable_latch level
  input wire logic I_CMD_VALID,                 // one-cycle command strobe
  input wire srwp_pkg::srwp_cmd_t I_CMD,        // command carrier
  output logic O_READY,                         // reload done, commands taken
  output logic O_PROT_HIGH,                     // protect_select_high
  output logic O_PROT_LOW,                      // protect_select_low
  output logic O_LOCK_BIT,                      // permanent_lock_bit in force
  output logic O_QE,                            // quad_lines_enable
  output logic [7:0] O_SR3,                     // pin_drive_protect_config
  output logic [1:0] O_DRIVE,                   // output_strength_field
  output logic O_BLOCK_SCHEME,                  // protection_scheme_select
  output logic O_HOLD_EN,                       // shared pin acts as hold
  output logic O_PIN_RESET_EN,                  // shared pin acts as reset
  output logic [2:0] O_PROT_TYPE,               // current protection type
  output logic O_WR_DONE,                       // status write landed, pulse
  output logic O_WR_REFUSED,                    // status write refused, pulse
  output logic [NUM_BLOCKS-1:0] O_BLOCK_LOCKS   // one lock bit per block
);

  // ----------------------------------------------------------------------
  // local sizes
  // ----------------------------------------------------------------------
  localparam int IDX_W = (NUM_BLOCKS > 1) ? $clog2(NUM_BLOCKS) : 1;

  // ----------------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------------
  srwp_pkg::srwp_state_t state_q, state_d;      // reload or run
  logic [1:0] psel_q, psel_d;                   // volatile {high, low}
  logic lock_q;                                 // lock copy caught at reload
  logic qe_q, qe_d;                             // quad lines enable
  srwp_pkg::srwp_sr3_t sr3_q, sr3_d;            // third status register
  logic [NUM_BLOCKS-1:0] locks_q;               // individual block locks
  logic done_q, refused_q;                      // write result pulses
  logic hold_en_q, pin_rst_en_q;                // shared pin function
  srwp_pkg::srwp_ptype_t ptype_q;               // registered protection type
  logic ready_q; // registered copy of the run state

  // ----------------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------------
  logic run;                                    // block is past its reload
  logic is_wrsr;                                // any status write opcode
  logic [7:0] sel;                              // register the write targets
  logic allowed;                                // guard verdict
  srwp_pkg::srwp_ptype_t ptype;                 // guard protection type
  logic wr_go;                                  // write lands this cycle
  logic blk_cmd;                                // lock or unlock this cycle
  logic blk_set;                                // value for the block bit
  logic [IDX_W-1:0] blk_idx;                    // addressed block

  assign run = (state_q == srwp_pkg::ST_RUN);

  // the four write opcodes and the register each one reaches
  always_comb begin
    is_wrsr = 1'b1;
    sel = 8'h00;
    case (I_CMD.opcode)
      srwp_pkg::OP_WRSR1: begin
        sel = srwp_pkg::SEL_SR1;
      end
      srwp_pkg::OP_WRSR2: begin
        sel = srwp_pkg::SEL_SR2;
      end
      srwp_pkg::OP_WRSR3: begin
        sel = srwp_pkg::SEL_SR3;
      end
      srwp_pkg::OP_WRSR_ADDR: begin
        sel = I_CMD.addr[7:0];
      end
      default: begin
        is_wrsr = 1'b0;
      end
    endcase
  end

  // protection decision lives in its own small module
  srwp_guard u_guard (
    .i_psel(psel_q),
    .i_lock(lock_q),
    .i_wp(I_WP_PIN),
    .i_qe(qe_q),
    .i_wel(I_WEL),
    .o_allowed(allowed),
    .o_ptype(ptype)
  );

  // a refused write simply falls through with no state touched
  assign wr_go = run & I_CMD_VALID & is_wrsr & allowed;

  // block commands only mean something under the block scheme
  assign blk_cmd = run & I_CMD_VALID & (sr3_q.scheme == srwp_pkg::SCHEME_BLOCK) &
                   ((I_CMD.opcode == srwp_pkg::OP_BLK_LOCK) |
                    (I_CMD.opcode == srwp_pkg::OP_BLK_UNLOCK));
  assign blk_set = (I_CMD.opcode == srwp_pkg::OP_BLK_LOCK);
  assign blk_idx = I_CMD.addr[BLOCK_SHIFT +: IDX_W];

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  // one reload cycle after any reset, so the stored copies are sampled
  // by a clock edge and never through the asynchronous path
  always_comb begin
    state_d = state_q;
    case (state_q)
      srwp_pkg::ST_LOAD: begin
        state_d = srwp_pkg::ST_RUN;
      end
      srwp_pkg::ST_RUN: begin
        if (I_SW_RESET) begin
          state_d = srwp_pkg::ST_LOAD;
        end
      end
      default: begin
        state_d = srwp_pkg::ST_LOAD;
      end
    endcase
  end

  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state_q <= srwp_pkg::ST_LOAD;
    end else begin
      state_q <= state_d;
    end
  end

  // ready pin gets its own flop, a decode of the state could glitch
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= (state_d == srwp_pkg::ST_RUN);
    end
  end

  // ----------------------------------------------------------------------
  // volatile protect selects
  // ----------------------------------------------------------------------
  always_comb begin
    psel_d = psel_q;
    if (state_q == srwp_pkg::ST_LOAD) begin
      case (I_NV_PSEL)
        srwp_pkg::PSEL_SOFTWARE: begin
          psel_d = srwp_pkg::PSEL_SOFTWARE;
        end
        srwp_pkg::PSEL_HARDWARE: begin
          psel_d = srwp_pkg::PSEL_HARDWARE;
        end
        srwp_pkg::PSEL_LOCKDOWN: begin
          // lockdown lifts to plain software protection
          psel_d = srwp_pkg::PSEL_SOFTWARE;
        end
        srwp_pkg::PSEL_LOCKED: begin
          if (I_NV_LOCK) begin
            psel_d = srwp_pkg::PSEL_LOCKED;
          end else begin
            psel_d = srwp_pkg::PSEL_HARDWARE;
          end
        end
        default: begin
          psel_d = srwp_pkg::PSEL_SOFTWARE;
        end
      endcase
    end else if (wr_go && sel == srwp_pkg::SEL_SR1) begin
      psel_d[0] = I_CMD.data[srwp_pkg::SR1_PROT_LOW_BIT];
    end else if (wr_go && sel == srwp_pkg::SEL_SR2) begin
      psel_d[1] = I_CMD.data[srwp_pkg::SR2_PROT_HIGH_BIT];
    end
  end

  // safest value until the reload cycle has run
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      psel_q <= srwp_pkg::PSEL_LOCKED;
    end else begin
      psel_q <= psel_d;
    end
  end

  // lock copy is only refreshed by a reset, so one-time stays one-time
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      lock_q <= 1'b1;
    end else if (state_q == srwp_pkg::ST_LOAD) begin
      lock_q <= I_NV_LOCK;
    end
  end

  // ----------------------------------------------------------------------
  // quad lines enable
  // ----------------------------------------------------------------------
  always_comb begin
    qe_d = qe_q;
    if (wr_go && sel == srwp_pkg::SEL_SR2) begin
      qe_d = I_CMD.data[srwp_pkg::SR2_QE_BIT];
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      qe_q <= srwp_pkg::QE_RESET;
    end else begin
      qe_q <= qe_d;
    end
  end

  // ----------------------------------------------------------------------
  // third status register
  // ----------------------------------------------------------------------
  // reserved fields are forced to zero; a reserved drive code is dropped
  // and the old strength kept, since no driver setting matches it
  always_comb begin
    sr3_d = sr3_q;
    if (wr_go && sel == srwp_pkg::SEL_SR3) begin
      sr3_d.pin_fn = I_CMD.data[7];
      sr3_d.scheme = I_CMD.data[2];
      if (I_CMD.data[6:5] != srwp_pkg::DRV_RESERVED) begin
        sr3_d.drive = I_CMD.data[6:5];
      end
      sr3_d.rsvd_hi = 2'h0;
      sr3_d.rsvd_lo = 2'h0;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      sr3_q <= srwp_pkg::SR3_RESET;
    end else begin
      sr3_q <= sr3_d;
    end
  end

  // ----------------------------------------------------------------------
  // shared pin function
  // ----------------------------------------------------------------------
  // quad lines win: the pin is then plain data and neither function runs
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      hold_en_q <= 1'b0;
      pin_rst_en_q <= 1'b0;
    end else begin
      hold_en_q <= ~qe_d & (sr3_d.pin_fn == srwp_pkg::PIN_FN_HOLD);
      pin_rst_en_q <= ~qe_d & (sr3_d.pin_fn == srwp_pkg::PIN_FN_RESET);
    end
  end

  // ----------------------------------------------------------------------
  // individual block locks
  // ----------------------------------------------------------------------
  genvar gb;
  generate
    for (gb = 0; gb < NUM_BLOCKS; gb = gb + 1) begin : g_lock
      always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
          locks_q[gb] <= srwp_pkg::BLOCK_LOCK_RESET;
        end else if (state_q == srwp_pkg::ST_LOAD) begin
          locks_q[gb] <= srwp_pkg::BLOCK_LOCK_RESET;
        end else if (blk_cmd && blk_idx == IDX_W'(gb)) begin
          locks_q[gb] <= blk_set;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // write result and protection type
  // ----------------------------------------------------------------------
  // a refused write only raises its own pulse, nothing else moves
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      done_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      done_q <= wr_go;
      refused_q <= run & I_CMD_VALID & is_wrsr & ~allowed;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ptype_q <= srwp_pkg::PT_OTP;
    end else begin
      ptype_q <= ptype;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, each straight from a register
  // ----------------------------------------------------------------------
  assign O_READY = ready_q;
  assign O_PROT_HIGH = psel_q[1];
  assign O_PROT_LOW = psel_q[0];
  assign O_LOCK_BIT = lock_q;
  assign O_QE = qe_q;
  assign O_SR3 = sr3_q;
  assign O_DRIVE = sr3_q.drive;
  assign O_BLOCK_SCHEME = sr3_q.scheme;
  assign O_HOLD_EN = hold_en_q;
  assign O_PIN_RESET_EN = pin_rst_en_q;
  assign O_PROT_TYPE = ptype_q;
  assign O_WR_DONE = done_q;
  assign O_WR_REFUSED = refused_q;
  assign O_BLOCK_LOCKS = locks_q;

endmodule

`default_nettype wire

/* File: verification/srwp_top_checker.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// status write guard checker
// ----------------------------------------
module srwp_top_checker #(
  parameter int NUM_BLOCKS = 64 // lockable blocks
) (
  input wire logic I_MCLK, // clock
  input wire logic I_RESETN, // reset, low
  input wire logic [1:0] I_NV_PSEL, // stored selects
  input wire logic I_NV_LOCK, // stored lock
  input wire logic I_WP_PIN, // wp pin
  input wire logic I_WEL, // latch
  input wire logic I_CMD_VALID, // strobe
  input wire srwp_pkg::srwp_cmd_t I_CMD, // command
  input wire logic O_READY, // ready
  input wire logic O_PROT_HIGH, // high select
  input wire logic O_PROT_LOW, // low select
  input wire logic O_QE, // quad lines
  input wire logic [7:0] O_SR3, // config reg
  input wire logic [1:0] O_DRIVE, // strength
  input wire logic O_BLOCK_SCHEME, // scheme
  input wire logic O_HOLD_EN, // hold
  input wire logic O_PIN_RESET_EN, // pin reset
  input wire logic O_WR_DONE, // landed
  input wire logic O_WR_REFUSED, // refused
  input wire logic [NUM_BLOCKS-1:0] O_BLOCK_LOCKS // locks
);
  logic wr; // a status write is taken at this edge
  logic [1:0] ps; // selects in force
  assign ps = {O_PROT_HIGH, O_PROT_LOW};
  assign wr = I_CMD_VALID && O_READY && (I_CMD.opcode inside {8'h01, 8'h31, 8'h11, 8'h71});
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RESETN);
  // selects 0,0: only the latch decides, pin has no say
  a_soft_latch_gate: assert property (wr && ps == 2'h0 |=> O_WR_DONE == $past(I_WEL))
    else $error("software mode write answer wrong");
  a_hw_pin_gate: assert property (wr && ps == 2'h1 && !O_QE |=> O_WR_DONE == ($past(I_WP_PIN) && $past(I_WEL)))
    else $error("pin mode write answer wrong");
  a_lockdown_refuse: assert property (wr && O_PROT_HIGH |=> O_WR_REFUSED && !O_WR_DONE)
    else $error("write landed while locked");
  a_refuse_keeps: assert property (O_WR_REFUSED |-> $stable(O_SR3) && $stable(O_QE) && $stable(ps))
    else $error("refused write changed state");
  // the reload decides the selects from the stored copy
  a_reload_map: assert property ($rose(O_READY) |-> ps == (($past(I_NV_PSEL) == 2'h3 && !$past(I_NV_LOCK)) ? 2'h1 : ($past(I_NV_PSEL) == 2'h2 ? 2'h0 : $past(I_NV_PSEL))))
    else $error("reload mapping wrong");
  a_reload_locks: assert property ($rose(O_READY) |-> &O_BLOCK_LOCKS)
    else $error("block locks not set at reload");
  a_quad_pins: assert property (O_QE && $past(O_QE) |-> !O_HOLD_EN && !O_PIN_RESET_EN)
    else $error("pin function on with quad lines");
  a_pin_select: assert property (O_READY && !O_QE && !$past(O_QE) && $stable(O_SR3) |-> O_PIN_RESET_EN == O_SR3[7] && O_HOLD_EN == !O_SR3[7])
    else $error("shared pin function wrong");
  // reserved strength code is never kept, reserved bits read zero
  a_cfg_fields: assert property (O_SR3[6:5] != 2'h0 && O_DRIVE == O_SR3[6:5] && O_BLOCK_SCHEME == O_SR3[2] && O_SR3[4:3] == 2'h0 && O_SR3[1:0] == 2'h0)
    else $error("config fields wrong");
  c_done: cover property (O_WR_DONE);
  c_refused: cover property (O_WR_REFUSED);
  c_reload: cover property ($rose(O_READY));
  c_unlocked: cover property (!(&O_BLOCK_LOCKS));
endmodule
bind srwp_top srwp_top_checker #(.NUM_BLOCKS(NUM_BLOCKS)) chk_u (.I_MCLK, .I_RESETN, .I_NV_PSEL,
  .I_NV_LOCK, .I_WP_PIN, .I_WEL, .I_CMD_VALID, .I_CMD, .O_READY, .O_PROT_HIGH, .O_PROT_LOW, .O_QE,
  .O_SR3, .O_DRIVE, .O_BLOCK_SCHEME, .O_HOLD_EN, .O_PIN_RESET_EN, .O_WR_DONE, .O_WR_REFUSED,
  .O_BLOCK_LOCKS);
`default_nettype wire

/* File: verification/srwp_host.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// serial host: issues one command per call
// ----------------------------------------
module srwp_host (
  input wire logic i_clk, // serial clock
  output logic o_valid, // command strobe
  output srwp_pkg::srwp_cmd_t o_cmd // command carrier
);
  // idle at time zero
  initial begin
    o_valid = 1'b0;
    o_cmd = '0;
  end
  // raised after a falling edge, taken at the next rising edge
  task automatic send(input logic [7:0] op, input logic [23:0] adr, input logic [7:0] dat);
    @(negedge i_clk);
    o_valid = 1'b1;
    o_cmd = {op, adr, dat};
    @(negedge i_clk);
    o_valid = 1'b0;
    o_cmd = ~o_cmd; // released carrier never repeats the last command
  endtask
endmodule
`default_nettype wire

/* File: verification/status_reg_write_protect_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module status_reg_write_protect_tb;
  logic I_MCLK, I_RESETN, I_SW_RESET, I_NV_LOCK, I_WP_PIN, I_WEL, I_CMD_VALID; // stimulus
  logic [1:0] I_NV_PSEL; // stored selects
  srwp_pkg::srwp_cmd_t I_CMD; // from the host model
  logic O_READY, O_PROT_HIGH, O_PROT_LOW, O_LOCK_BIT, O_QE, O_BLOCK_SCHEME, O_HOLD_EN; // status
  logic O_PIN_RESET_EN, O_WR_DONE, O_WR_REFUSED; // pin and answer
  logic [7:0] O_SR3; // config register
  logic [1:0] O_DRIVE; // strength
  logic [2:0] O_PROT_TYPE; // protection type
  logic [63:0] O_BLOCK_LOCKS; // block locks
  int miscompares, cmp_count; // tallies
  srwp_top dut_u (.I_MCLK, .I_RESETN, .I_SW_RESET, .I_NV_PSEL, .I_NV_LOCK, .I_WP_PIN, .I_WEL,
    .I_CMD_VALID, .I_CMD, .O_READY, .O_PROT_HIGH, .O_PROT_LOW, .O_LOCK_BIT, .O_QE, .O_SR3,
    .O_DRIVE, .O_BLOCK_SCHEME, .O_HOLD_EN, .O_PIN_RESET_EN, .O_PROT_TYPE, .O_WR_DONE,
    .O_WR_REFUSED, .O_BLOCK_LOCKS);
  srwp_host host_u (.i_clk(I_MCLK), .o_valid(I_CMD_VALID), .o_cmd(I_CMD));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // one command, then its answer pulses {done, refused}
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic [7:0] d,
                     input logic [1:0] ans);
    host_u.send(op, a, d);
    chk("answer", {O_WR_DONE, O_WR_REFUSED}, ans);
  endtask
  // reset held three cycles, stored copy set meanwhile
  task automatic rst(input logic [1:0] nv, input logic lk);
    @(negedge I_MCLK);
    I_RESETN = 1'b0;
    I_NV_PSEL = nv;
    I_NV_LOCK = lk;
    repeat (3) @(negedge I_MCLK);
    I_RESETN = 1'b1;
    repeat (2) @(negedge I_MCLK);
  endtask
  task automatic swr();
    @(negedge I_MCLK);
    I_SW_RESET = 1'b1;
    @(negedge I_MCLK);
    I_SW_RESET = 1'b0;
    repeat (2) @(negedge I_MCLK);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------
  initial begin
    I_MCLK = 1'b0;
    forever #2 I_MCLK = ~I_MCLK;
  end
  // whole run is about a hundred cycles, so this only trips on a hang
  initial begin
    #20000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    miscompares = 0;
    cmp_count = 0;
    I_RESETN = 1'b0;
    I_SW_RESET = 1'b0;
    I_NV_PSEL = 2'h0;
    I_NV_LOCK = 1'b0;
    I_WP_PIN = 1'b1;
    I_WEL = 1'b1;
    for (int k = 0; k < 8; k++) begin
      rst(k[2:1], k[0]);
      chk("selects", {O_PROT_HIGH, O_PROT_LOW}, (k == 7) ? 2'h3 : (k == 6 || k[2:1] == 1) ? 2'h1 : 2'h0);
      chk("locks", O_BLOCK_LOCKS, '1);
      chk("type", O_PROT_TYPE, (k == 7) ? 3'h4 : (k == 6 || k[2:1] == 1) ? 3'h2 : 3'h0);
    end
    cmd(8'h01, 24'h0, 8'h00, 2'b01);
    chk("lock bit", O_LOCK_BIT, 1'b1);
    $display("reload test done");
    rst(2'h0, 1'b0);
    chk("config", O_SR3, 8'h20);
    chk("hold", O_HOLD_EN, 1'b1);
    I_WEL = 1'b0;
    cmd(8'h11, 24'h0, 8'hC4, 2'b01);
    chk("config", O_SR3, 8'h20);
    I_WEL = 1'b1;
    cmd(8'h11, 24'h0, 8'hC4, 2'b10);
    chk("fields", {O_SR3, O_DRIVE, O_BLOCK_SCHEME}, {8'hC4, 2'h2, 1'b1});
    cmd(8'h39, 24'h050000, 8'h00, 2'b00);
    chk("unlock", O_BLOCK_LOCKS[5], 1'b0);
    chk("pins", {O_HOLD_EN, O_PIN_RESET_EN}, 2'b01);
    cmd(8'h36, 24'h050000, 8'h00, 2'b00);
    chk("relock", O_BLOCK_LOCKS, '1);
    cmd(8'h11, 24'h0, 8'h60, 2'b10);
    cmd(8'h11, 24'h0, 8'h00, 2'b10);
    chk("drive", O_DRIVE, 2'h3);
    cmd(8'h39, 24'h050000, 8'h00, 2'b00);
    chk("region", O_BLOCK_LOCKS, '1);
    cmd(8'h71, 24'h000003, 8'h20, 2'b10);
    chk("config", O_SR3, 8'h20);
    $display("config test done");
    cmd(8'h31, 24'h0, 8'h02, 2'b10);
    cmd(8'h01, 24'h0, 8'h80, 2'b10);
    chk("quad pins", {O_QE, O_HOLD_EN, O_PIN_RESET_EN}, 3'b100);
    I_WP_PIN = 1'b0;
    cmd(8'h71, 24'h000001, 8'h80, 2'b10);
    cmd(8'h31, 24'h0, 8'h00, 2'b10);
    cmd(8'h01, 24'h0, 8'h80, 2'b01);
    chk("selects", {O_PROT_HIGH, O_PROT_LOW}, 2'h1);
    chk("type", O_PROT_TYPE, 3'h1);
    I_WP_PIN = 1'b1;
    cmd(8'h31, 24'h0, 8'h01, 2'b10);
    chk("selects", {O_PROT_HIGH, O_PROT_LOW}, 2'h3);
    cmd(8'h11, 24'h0, 8'h20, 2'b01);
    $display("guard test done");
    I_NV_PSEL = 2'h2;
    swr();
    chk("selects", {O_PROT_HIGH, O_PROT_LOW}, 2'h0);
    cmd(8'h31, 24'h0, 8'h01, 2'b10);
    cmd(8'h01, 24'h0, 8'h00, 2'b01);
    chk("type", O_PROT_TYPE, 3'h3);
    swr();
    cmd(8'h01, 24'h0, 8'h00, 2'b10);
    $display("software reset test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
